// file: encoder_serial_acquisition.v
// Serial encoder position acquisition with timeout, additional data and FIFO
`timescale 1ns/1ps
`default_nettype none
`include "enc_acq_map.vh"
module encoder_serial_acquisition #(
    parameter LONG_CYC = `CALC_LONG_CYC,
    parameter SHORT_CYC = `CALC_SHORT_CYC,
    parameter AW = 18
) (
    input wire clk_sys, // 200 MHz system clock
    input wire reset, // Synchronous, active high
    input wire [1:0] opMode, // Operating mode
    input wire [1:0] addMode, // Additional-data option
    input wire calcShort, // 1 selects short calculation time
    input wire calcSetValid, // Pulse: take calcShort
    input wire [4:0] fixedSel1, // Fixed selection for word 1
    input wire [4:0] fixedSel2, // Fixed selection for word 2
    input wire fixedEn1, // Fixed option sends word 1
    input wire fixedEn2, // Fixed option sends word 2
    input wire ringWrEn, // Pulse: write ring entry
    input wire [3:0] ringWrAddr, // Ring entry index 0..9
    input wire ringWrWord, // Entry targets word 2 when high
    input wire [4:0] ringWrSel, // Entry selection code
    input wire trigger, // Pulse: trigger event
    input wire latchCmd, // Pulse: capture serial and incremental
    input wire [31:0] incPos, // Incremental position, same clock
    output reg linkClk, // Link clock out
    output reg linkReq, // Request strobe towards transceiver
    output reg [9:0] linkSupp, // Supplement: word flag, sel code, index
    input wire linkDone, // Transceiver: frame finished (async)
    input wire [`POS_WIDTH-1:0] linkPos, // Received position, stable at done
    input wire [`ADD_WIDTH-1:0] linkAdd1, // Received word 1
    input wire [`ADD_WIDTH-1:0] linkAdd2, // Received word 2
    output reg [`POS_WIDTH+2*`ADD_WIDTH+19:0] smpData, // Sample word
    output reg smpValid, // Sample valid
    input wire smpReady, // Consumer takes sample
    output reg [`POS_WIDTH+31:0] latchData, // Serial and incremental pair
    output reg latchValid, // Pulse: latch response
    output reg calcShortQ, // Current setting readback
    output reg busy, // Request in flight
    output reg overflow // Sticky: trigger lost while a request is in flight
);
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_PUSH = 2'h2;
    localparam FW = `POS_WIDTH + 2 * `ADD_WIDTH + 20;

    reg [1:0] state_q;
    reg [AW-1:0] timer_q;
    reg [7:0] seq_q;
    reg [3:0] ringIdx_q;
    reg ringWord [0:`RING_DEPTH-1];
    reg [4:0] ringSel [0:`RING_DEPTH-1];
    reg [4:0] sel1_q;
    reg [4:0] sel2_q;
    reg isLatch_q;
    reg timeout_q;
    reg [`POS_WIDTH-1:0] pos_q;
    reg [`ADD_WIDTH-1:0] add1_q;
    reg [`ADD_WIDTH-1:0] add2_q;
    reg [31:0] incLatch_q;
    reg [2:0] clkDiv_q;
    reg doneMeta_q;
    reg doneSync_q;
    reg donePrev_q;
    wire doneRise;
    wire [FW-1:0] fifoIn;
    wire fifoInReady;
    wire [FW-1:0] fifoOut;
    wire fifoOutValid;
    wire streamMode;
    wire [AW-1:0] limit;
    wire startReq;

    // Done crosses from the transceiver through two flops
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            doneMeta_q <= 1'b0;
            doneSync_q <= 1'b0;
            donePrev_q <= 1'b0;
        end
        else
        begin
            doneMeta_q <= linkDone;
            doneSync_q <= doneMeta_q;
            donePrev_q <= doneSync_q;
        end
    end
    assign doneRise = doneSync_q && !donePrev_q;

    // Extra data only outside polling mode
    assign streamMode = (opMode != `MODE_POLLING);
    assign limit = calcShortQ ? SHORT_CYC[AW-1:0] : LONG_CYC[AW-1:0];
    assign startReq = (state_q == ST_IDLE) && (trigger || latchCmd);

    // Ring table writes
    always @(posedge clk_sys)
    begin
        if (ringWrEn && ringWrAddr < `RING_DEPTH)
        begin
            ringWord[ringWrAddr] <= ringWrWord;
            ringSel[ringWrAddr] <= ringWrSel;
        end
    end

    // Free-running divider for link clock, 12.5 MHz, well above the short-setting floor
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            clkDiv_q <= 3'h0;
            linkClk <= 1'b1;
        end
        else
        begin
            clkDiv_q <= clkDiv_q + 3'h1;
            if (clkDiv_q == 3'h7)
                linkClk <= !linkClk;
        end
    end

    // Calculation-time setting, long after reset
    always @(posedge clk_sys)
    begin
        if (reset)
            calcShortQ <= 1'b0;
        else if (calcSetValid)
            calcShortQ <= calcShort;
    end

    // Request sequencer with supervision timer
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            state_q <= ST_IDLE;
            timer_q <= {AW{1'b0}};
            seq_q <= 8'h00;
            ringIdx_q <= 4'h0;
            sel1_q <= `SEL_RESET;
            sel2_q <= `SEL_RESET;
            isLatch_q <= 1'b0;
            timeout_q <= 1'b0;
            pos_q <= {`POS_WIDTH{1'b0}};
            add1_q <= {`ADD_WIDTH{1'b0}};
            add2_q <= {`ADD_WIDTH{1'b0}};
            incLatch_q <= 32'h0;
            linkReq <= 1'b0;
            linkSupp <= 10'h000;
            busy <= 1'b0;
            latchData <= {(`POS_WIDTH+32){1'b0}};
            latchValid <= 1'b0;
            overflow <= 1'b0;
        end
        else
        begin
            linkReq <= 1'b0;
            latchValid <= 1'b0;
            if (trigger && state_q != ST_IDLE)
                overflow <= 1'b1;
            case (state_q)
                ST_IDLE:
                begin
                    if (startReq)
                    begin
                        // One request per trigger; command trigger has priority
                        linkReq <= 1'b1;
                        isLatch_q <= latchCmd;
                        if (latchCmd)
                            incLatch_q <= incPos;
                        timer_q <= {AW{1'b0}};
                        timeout_q <= 1'b0;
                        busy <= 1'b1;
                        state_q <= ST_WAIT;
                        linkSupp <= 10'h000;
                        if (streamMode && addMode == `ADD_VARIABLE && !latchCmd)
                        begin
                            // Only one of the two selections changes per request
                            linkSupp <= {ringWord[ringIdx_q], ringSel[ringIdx_q],
                                ringIdx_q};
                            if (ringWord[ringIdx_q])
                                sel2_q <= ringSel[ringIdx_q];
                            else
                                sel1_q <= ringSel[ringIdx_q];
                            ringIdx_q <= (ringIdx_q == `RING_DEPTH - 1) ? 4'h0
                                : ringIdx_q + 4'h1;
                        end
                    end
                end
                ST_WAIT:
                begin
                    timer_q <= timer_q + 1'b1;
                    if (doneRise)
                    begin
                        pos_q <= linkPos;
                        add1_q <= linkAdd1;
                        add2_q <= linkAdd2;
                        state_q <= ST_PUSH;
                    end
                    else if (timer_q >= limit - 1'b1)
                    begin
                        timeout_q <= 1'b1;
                        state_q <= ST_PUSH;
                    end
                end
                default:
                begin
                    // Latch answer bypasses the FIFO
                    if (isLatch_q)
                    begin
                        latchData <= {pos_q, incLatch_q};
                        latchValid <= 1'b1;
                        busy <= 1'b0;
                        state_q <= ST_IDLE;
                        seq_q <= seq_q + 8'h01;
                    end
                    else if (fifoInReady)
                    begin
                        busy <= 1'b0;
                        state_q <= ST_IDLE;
                        seq_q <= seq_q + 8'h01;
                    end
                end
            endcase
        end
    end

    // Sample word: seq, timeout, word flags, data; absent words forced to zero
    wire sendW1 = streamMode && (addMode == `ADD_VARIABLE ||
        (addMode == `ADD_FIXED && fixedEn1));
    wire sendW2 = streamMode && (addMode == `ADD_VARIABLE ||
        (addMode == `ADD_FIXED && fixedEn2));
    wire [4:0] tag1 = (addMode == `ADD_FIXED) ? fixedSel1 : sel1_q;
    wire [4:0] tag2 = (addMode == `ADD_FIXED) ? fixedSel2 : sel2_q;
    assign fifoIn = {seq_q, timeout_q, sendW1, sendW2, tag1[4:0], tag2[3:0],
        pos_q, sendW1 ? add1_q : {`ADD_WIDTH{1'b0}},
        sendW2 ? add2_q : {`ADD_WIDTH{1'b0}}};

    sample_fifo #(
        .WIDTH(FW),
        .DEPTH(`FIFO_DEPTH),
        .AW(5)
    ) u_fifo (
        .clk_sys(clk_sys),
        .reset(reset),
        .inData(fifoIn),
        .inValid((state_q == ST_PUSH) && !isLatch_q),
        .inReady(fifoInReady),
        .outData(fifoOut),
        .outValid(fifoOutValid),
        .outReady(smpReady && smpValid)
    );

    // Registered output stage tracks the FIFO head
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            smpData <= {FW{1'b0}};
            smpValid <= 1'b0;
        end
        else
        begin
            smpData <= fifoOut;
            smpValid <= fifoOutValid && !(smpReady && smpValid);
        end
    end
endmodule
`default_nettype wire

// file: enc_acq_map.vh
// Constants for the serial encoder position acquisition block
`ifndef ENC_ACQ_MAP_VH
`define ENC_ACQ_MAP_VH
`define CLK_PERIOD_PS 5000
`define CALC_LONG_NS 1000000
`define CALC_SHORT_NS 15000
`define CALC_LONG_CYC ((`CALC_LONG_NS * 1000) / `CLK_PERIOD_PS)
`define CALC_SHORT_CYC ((`CALC_SHORT_NS * 1000) / `CLK_PERIOD_PS)
`define POS_WIDTH 48
`define ADD_WIDTH 16
`define RING_DEPTH 10
`define MODE_POLLING 2'h0
`define MODE_SOFT_RT 2'h1
`define MODE_STREAM 2'h2
`define MODE_RECORD 2'h3
`define ADD_NONE 2'h0
`define ADD_FIXED 2'h1
`define ADD_VARIABLE 2'h2
`define SEL_RESET 3'h0
`define FIFO_DEPTH 32
`endif

// file: sample_fifo.v
// Synchronous FIFO for finished position samples
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire clk_sys, // System clock
    input wire reset, // Synchronous reset
    input wire [WIDTH-1:0] inData, // Write word
    input wire inValid, // Write request
    output wire inReady, // Not full
    output wire [WIDTH-1:0] outData, // Head word
    output wire outValid, // Not empty
    input wire outReady // Reader takes head
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr_q;
    reg [AW-1:0] rdPtr_q;
    reg [AW:0] count_q;
    wire doWrite;
    wire doRead;

    // Handshakes on both sides
    assign inReady = (count_q != DEPTH[AW:0]);
    assign outValid = (count_q != {(AW+1){1'b0}});
    assign doWrite = inValid && inReady;
    assign doRead = outValid && outReady;
    assign outData = mem[rdPtr_q];

    // Storage array has no reset, only pointers and count do
    always @(posedge clk_sys)
    begin
        if (doWrite)
            mem[wrPtr_q] <= inData;
    end

    // Pointers wrap at DEPTH, which need not be a power of two
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            wrPtr_q <= {AW{1'b0}};
            rdPtr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
        end
        else
        begin
            if (doWrite)
                wrPtr_q <= (wrPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_q + 1'b1;
            if (doRead)
                rdPtr_q <= (rdPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_q + 1'b1;
            if (doWrite && !doRead)
                count_q <= count_q + 1'b1;
            else if (doRead && !doWrite)
                count_q <= count_q - 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: enc_acq_asserts.sv
// Port assertions for the encoder acquisition block
`timescale 1ns/1ps
`default_nettype none
module enc_acq_asserts #(parameter LONG_CYC = 40, parameter SHORT_CYC = 20) (
    input wire logic clk_sys, // Clock
    input wire logic reset, // Reset
    input wire logic [1:0] addMode, // Option
    input wire logic calcShort, // Setting
    input wire logic calcSetValid, // Strobe
    input wire logic trigger, // Trigger
    input wire logic latchCmd, // Latch
    input wire logic linkReq, // Request
    input wire logic [9:0] linkSupp, // Supplement
    input wire logic [99:0] smpData, // Sample
    input wire logic smpValid, // Valid
    input wire logic smpReady, // Ready
    input wire logic latchValid, // Answer
    input wire logic calcShortQ, // Readback
    input wire logic busy // In flight
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    logic [17:0] busyCnt;
    logic [3:0] lastIdx;
    logic seenIdx;
    // Consumer stalls restart the count, since a full buffer may hold busy
    always_ff @(posedge clk_sys)
    begin
        busyCnt <= (reset || !busy || !smpReady) ? 18'h0 : busyCnt + 18'h1;
        seenIdx <= !reset && addMode == 2'h2 && (seenIdx || linkReq);
        lastIdx <= linkReq ? linkSupp[3:0] : lastIdx;
    end
    sequence sTake;
        (trigger || latchCmd) && !busy;
    endsequence
    sequence sIssue;
        linkReq && busy ##1 !linkReq;
    endsequence
    a_take_issues_req: assert property (sTake |=> sIssue)
        else $error("no request");
    a_reset_long: assert property (disable iff (1'h0) reset |=> !calcShortQ)
        else $error("not long");
    a_calc_take: assert property (calcSetValid |=> calcShortQ == $past(calcShort))
        else $error("setting lost");
    a_busy_bound: assert property (busyCnt <= (calcShortQ ? SHORT_CYC : LONG_CYC) + 12)
        else $error("no timeout");
    a_supp_plain: assert property (linkReq && addMode != 2'h2 |-> linkSupp == 10'h0)
        else $error("stray supplement");
    a_ring_step:
        assert property (linkReq && seenIdx && addMode == 2'h2 |->
            linkSupp[3:0] == (lastIdx == 4'h9 ? 4'h0 : lastIdx + 4'h1)) else $error("ring skip");
    a_smp_stands: assert property (smpValid && !smpReady |=> smpValid && $stable(smpData))
        else $error("sample moved");
    a_latch_pulse: assert property (latchValid |=> !latchValid)
        else $error("latch too long");
endmodule
bind encoder_serial_acquisition enc_acq_asserts #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC))
    enc_acq_asserts_inst (.clk_sys, .reset, .addMode, .calcShort, .calcSetValid, .trigger,
    .latchCmd, .linkReq, .linkSupp, .smpData, .smpValid, .smpReady, .latchValid, .calcShortQ,
    .busy);
`default_nettype wire

// file: enc_link_model.sv
// Behavioural encoder on the serial link
`timescale 1ns/1ps
`default_nettype none
module enc_link_model (
    input wire logic linkReq, // Request
    input wire logic [9:0] linkSupp, // Supplement
    input wire logic silent, // Never answer
    input wire logic [7:0] slots, // Delay, 160 ns units
    input wire logic [47:0] posVal, // Position sent
    output logic linkDone, // Frame done
    output logic [47:0] linkPos, // Position
    output logic [15:0] linkAdd1, // Word 1
    output logic [15:0] linkAdd2 // Word 2
);
    logic [9:0] suppSeen;
    // Idle lines at power-up
    initial {linkDone, linkPos, linkAdd1, linkAdd2} = 81'h0;
    // One frame per request; after done falls the lines scramble rather than hold
    always @(posedge linkReq)
    begin
        // Sample off the edge: request and supplement update in the same step
        #1;
        suppSeen = linkSupp;
        if (!silent)
        begin
            #(160 * slots);
            {linkPos, linkAdd1, linkAdd2} = {posVal, 6'h0, suppSeen, ~posVal[15:0]};
            linkDone = 1'h1;
            #20; // Short pulse so a back-to-back request is not missed
            linkDone = 1'h0;
            {linkPos, linkAdd1, linkAdd2} = ~{linkPos, linkAdd1, linkAdd2};
        end
    end
endmodule
`default_nettype wire

// file: encoder_serial_acquisition_tb.sv
// Self-checking bench for the encoder acquisition block
`timescale 1ns/1ps
`default_nettype none
module encoder_serial_acquisition_tb;
    localparam int SHORT = 100;
    logic clk_sys, reset, calcShort, calcSetValid, fixedEn1, fixedEn2, ringWrEn, ringWrWord;
    logic trigger, latchCmd, smpReady, linkDone, silent, linkClk, linkReq, smpValid;
    logic latchValid, calcShortQ, busy, overflow;
    logic [1:0] opMode, addMode;
    logic [4:0] fixedSel1, fixedSel2, ringWrSel;
    logic [3:0] ringWrAddr;
    logic [31:0] incPos;
    logic [47:0] linkPos, posVal;
    logic [15:0] linkAdd1, linkAdd2;
    logic [9:0] linkSupp;
    logic [99:0] smpData, s;
    logic [79:0] latchData;
    logic [7:0] slots, lastSeq;
    int err_count = 0, checked = 0, n;
    encoder_serial_acquisition #(.LONG_CYC(400), .SHORT_CYC(SHORT))
    encoder_serial_acquisition_inst (.clk_sys, .reset, .opMode, .addMode, .calcShort,
        .calcSetValid, .fixedSel1, .fixedSel2, .fixedEn1, .fixedEn2, .ringWrEn, .ringWrAddr,
        .ringWrWord, .ringWrSel, .trigger, .latchCmd, .incPos, .linkClk, .linkReq, .linkSupp,
        .linkDone, .linkPos, .linkAdd1, .linkAdd2, .smpData, .smpValid, .smpReady, .latchData,
        .latchValid, .calcShortQ, .busy, .overflow);
    enc_link_model enc_link_model_inst (.linkReq, .linkSupp, .silent, .slots, .posVal,
        .linkDone, .linkPos, .linkAdd1, .linkAdd2);
    task cmp(input string what, input logic [99:0] e, input logic [99:0] g);
        checked++;
        err_count += int'(e !== g);
        if (e !== g)
            $display("MISMATCH %s expected %h seen %h", what, e, g);
    endtask
    task conclude;
        $display("Checks %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Inputs move 1 ns after the edge, so no race with the design
    task step;
        @(posedge clk_sys);
        #1;
    endtask
    // Every wait is capped; running out is a mismatch
    task guard;
        cmp("wait", 1'h1, n < 3000);
        if (n >= 3000)
            conclude;
    endtask
    task fire(input logic lat);
        for (n = 0; busy !== 1'h0 && n < 3000; n++) step;
        guard;
        {trigger, latchCmd} = {!lat, lat};
        step;
        {trigger, latchCmd} = 2'h0;
    endtask
    task run(input logic to, input logic [1:0] w);
        posVal = posVal + 48'h1234_5678_9abc;
        fire(1'h0);
        for (n = 0; smpValid !== 1'h1 && n < 3000; n++) step;
        guard;
        s = smpData;
        step;
        if (!to)
        begin
            cmp("pos", posVal, s[79:32]);
            cmp("add2", w[0] ? {~posVal[15:0]} : 16'h0, s[15:0]);
        end
        cmp("timeout", to, s[91]);
        cmp("words", w, s[90:89]);
        cmp("seq", {lastSeq + 8'h1}, s[99:92]);
        lastSeq = s[99:92];
    endtask
    task tPlain;
        cmp("calcShortQ", 1'h0, calcShortQ);
        opMode = 2'h1;
        run(1'h0, 2'h0);
        run(1'h0, 2'h0);
    endtask
    // Fixed selection is set in polling, then each streaming mode runs
    task tFixed;
        for (int i = 1; i < 4; i++)
        begin
            opMode = 2'h0;
            {addMode, fixedEn2, fixedEn1} = {2'h1, i[1:0]};
            step;
            opMode = i[1:0];
            run(1'h0, {i[0], i[1]});
            cmp("fixTags", {fixedSel1, fixedSel2[3:0]}, s[88:80]);
        end
    endtask
    task tVar;
        opMode = 2'h0;
        for (int i = 0; i < 10; i++)
        begin
            {ringWrEn, ringWrAddr, ringWrWord, ringWrSel} = {1'h1, i[3:0], i[0], i[4:0] + 5'h3};
            step;
        end
        ringWrEn = 1'h0;
        {addMode, opMode} = 4'ha;
        for (int i = 0; i < 11; i++)
        begin
            run(1'h0, 2'h3);
            s[9:0] = enc_link_model_inst.suppSeen;
            cmp("suppWord", s[0], s[9]);
            cmp("suppSel", s[3:0] + 4'h3, s[8:4]);
            cmp("add1", {6'h0, s[9:0]}, s[31:16]);
        end
    endtask
    // Short setting only while the link clock runs above 1 MHz
    task tTimeout;
        n = 0;
        repeat (160)
        begin
            s[0] = linkClk;
            step;
            n += int'(s[0] !== linkClk);
        end
        cmp("linkClkToggles", 8'h14, n);
        {addMode, opMode, calcShort, calcSetValid} = 6'h07;
        step;
        calcSetValid = 1'h0;
        cmp("calcShortQ", 1'h1, calcShortQ);
        silent = 1'h1;
        run(1'h1, 2'h0);
        cmp("shortWait", 1'h1, n > SHORT - 10);
        {silent, calcShort, calcSetValid} = 3'h1;
        slots = 8'h0a;
        step;
        calcSetValid = 1'h0;
        run(1'h0, 2'h0);
    endtask
    task tLatch;
        incPos = 32'h89ab_cdef;
        fire(1'h1);
        // Moving the input after the request proves it was taken at the trigger
        incPos = ~incPos;
        for (n = 0; latchValid !== 1'h1 && n < 3000; n++) step;
        guard;
        cmp("latch", {posVal, 32'h89ab_cdef}, latchData);
    endtask
    // Consumer stalls until the buffer refuses, then drains it
    task tFull;
        {smpReady, slots} = 9'h001;
        repeat (40)
        begin
            trigger = 1'h1;
            step;
            trigger = 1'h0;
            repeat (60) step;
        end
        cmp("overflow", 1'h1, overflow);
        smpReady = 1'h1;
        n = 0;
        repeat (300)
        begin
            step;
            n += int'(smpValid === 1'h1);
        end
        cmp("drained", 1'h1, n > 31 && n < 41);
    endtask
    // 200 MHz system clock
    initial
    begin
        clk_sys = 1'h0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // Six cycles of reset, then the scenarios
    initial
    begin
        {reset, calcShort, calcSetValid, fixedEn1, fixedEn2, ringWrEn, ringWrWord} = 7'h40;
        {trigger, latchCmd, silent, opMode, addMode, ringWrAddr} = 11'h0;
        {fixedSel1, fixedSel2, ringWrSel, incPos, posVal} = {5'h03, 5'h0c, 85'h0};
        {smpReady, slots, lastSeq} = 17'h102ff;
        repeat (6) @(posedge clk_sys);
        #1;
        reset = 1'h0;
        tPlain;
        tFixed;
        tVar;
        tTimeout;
        tLatch;
        tFull;
        conclude;
    end
endmodule
`default_nettype wire
